// file: hw/nsic_params.svh
// Constants of the near-infrared sensor I2C link: addresses, offsets, fields, reset values, timing
`ifndef NSIC_PARAMS_SVH
`define NSIC_PARAMS_SVH

// Target address on the serial bus
`define NSIC_TGT_ADDR      7'h2a

// Register pointer values inside the sensor
`define NSIC_PTR_CTRL      8'h00
`define NSIC_PTR_TIM_HI    8'h01
`define NSIC_PTR_TIM_LO    8'h02
`define NSIC_PTR_RES_HI    8'h03
`define NSIC_PTR_RES_LO    8'h04
`define NSIC_PTR_LED_CTRL  8'h0e
`define NSIC_PTR_LED_CUR   8'h0f

// Measurement control fields
`define NSIC_CTRL_ADC_RST  7
`define NSIC_CTRL_STBY     6
`define NSIC_CTRL_MON      5
`define NSIC_CTRL_REG_RST  4
`define NSIC_CTRL_GAIN     3
`define NSIC_CTRL_MODE     2
`define NSIC_CTRL_STEP_HI  1
`define NSIC_CTRL_STEP_LO  0

// LED control fields
`define NSIC_LED_RST       7
`define NSIC_LED_STBY      6
`define NSIC_LED_DC        5

// Reset values
`define NSIC_CTRL_INIT     8'hd4
`define NSIC_LED_CTRL_INIT 8'hc0
`define NSIC_LED_CUR_INIT  8'h00
`define NSIC_TIM_INIT      16'h0000

// Timing: clock period and integration steps in ns
`define NSIC_CLK_NS        40
`define NSIC_STEP0_NS      32000
`define NSIC_STEP1_NS      500000
`define NSIC_STEP2_NS      4000000
`define NSIC_STEP3_NS      65500000
`define NSIC_STEP0_CYC     (`NSIC_STEP0_NS / `NSIC_CLK_NS)
`define NSIC_STEP1_CYC     (`NSIC_STEP1_NS / `NSIC_CLK_NS)
`define NSIC_STEP2_CYC     (`NSIC_STEP2_NS / `NSIC_CLK_NS)
`define NSIC_STEP3_CYC     (`NSIC_STEP3_NS / `NSIC_CLK_NS)
// Steps per fixed-time channel, and steps per manual timing count
`define NSIC_FIX_STEPS     2
`define NSIC_MAN_STEPS     2

// Host side: quarter of a 400 kHz SCL period, least time rounded up
`define NSIC_QTR_NS        625
`define NSIC_QTR_CYC       ((`NSIC_QTR_NS + `NSIC_CLK_NS - 1) / `NSIC_CLK_NS)

// Host APB register offsets
`define NSIC_APB_CMD       8'h00
`define NSIC_APB_PTR       8'h04
`define NSIC_APB_WDATA     8'h08
`define NSIC_APB_STATUS    8'h0c
`define NSIC_APB_RDATA     8'h10

`endif

// file: hw/nsic_pkg.sv
// Types shared by both ends of the sensor link
package nsic_pkg;

	typedef enum logic [1:0] {DS_IDLE, DS_ADDR, DS_WR, DS_RD} nsic_dev_state_e;

	typedef enum logic [2:0] {IT_START, IT_TX, IT_RXA, IT_RXN, IT_STOP} nsic_item_e;

	typedef enum logic {HS_IDLE, HS_RUN} nsic_host_state_e;

endpackage

// file: hw/nsic_if.sv
// Open-drain serial bus between host controller and sensor
`timescale 1ns/1ps

interface nsic_if;
	logic h_scl_o;
	logic h_scl_oe;
	logic h_sda_o;
	logic h_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic scl;
	logic sda;

	// Pulled-up wires: a driver that is enabled pulls its value onto the line
	assign scl = h_scl_oe ? h_scl_o : 1'b1;
	assign sda = (h_sda_oe ? h_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);

	modport host (output h_scl_o, output h_scl_oe, output h_sda_o, output h_sda_oe, input sda);
	modport dev (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface

// file: hw/nsic_device.sv
// Sensor end: I2C target, register file, measurement timer and LED driver control
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "nsic_params.svh"
//
// Behaviour
// - Answer at 0x2A; direction bit selects read/write
// - First written byte sets the register pointer
// - Next bytes fill successive registers, timing high first
// - Measurement starts when converter reset falls with standby clear
// - 0x81 then 0x01 starts fixed-time measuring
// - Fixed mode repeats until reset or standby
// - Step code 01 is 0.5 ms, 1.0 ms/channel
// - Host waits past integration before reading
// - 0x8D then 0x0D runs manual low-gain measurement
// - Manual count 357 gives 357 ms integration
// - Manual mode measures once, then enters standby
// - Pointer 0x03 read returns high then low byte
// - 0x0E 0xA0 holds LED reset, DC drive
// - Following byte sets LED current, 0x60 is 48 mA
// - LED current is sum of 64/32/16/8 mA weights
// - 0x20 starts LED drive, 0xC0 stops it
// - Released LED keeps driving until standby set
//
module nsic_device #(
	parameter int unsigned STEP0_CYC = `NSIC_STEP0_CYC,
	parameter int unsigned STEP1_CYC = `NSIC_STEP1_CYC,
	parameter int unsigned STEP2_CYC = `NSIC_STEP2_CYC,
	parameter int unsigned STEP3_CYC = `NSIC_STEP3_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	nsic_if.dev              bus,
	input  wire logic [15:0] sample_data,
	output logic             integrating,
	output logic             gain_low,
	output logic             led_drive,
	output logic             led_dc_mode,
	output logic [6:0]       led_ma
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and bus events

	// Stage [0] only feeds stage [1]; stage [2] is the previous settled value
	logic [2:0] scl_s_q;
	logic [2:0] sda_s_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
		end else begin
			scl_s_q <= {scl_s_q[1:0], bus.scl};
			sda_s_q <= {sda_s_q[1:0], bus.sda};
		end
	end

	wire scl_hi    = scl_s_q[1] & scl_s_q[2];
	wire scl_rise  = scl_s_q[1] & ~scl_s_q[2];
	wire scl_fall  = ~scl_s_q[1] & scl_s_q[2];
	wire bus_start = scl_hi & sda_s_q[2] & ~sda_s_q[1];
	wire bus_stop  = scl_hi & ~sda_s_q[2] & sda_s_q[1];

	////////////////////////////////////////////////////////////////////////////////
	// Target state

	nsic_pkg::nsic_dev_state_e state_q;
	logic [3:0]                bit_cnt_q;
	logic [7:0]                shift_q;
	logic [7:0]                tx_q;
	logic [7:0]                ptr_q;
	logic                      ptr_phase_q;
	logic                      rd_dir_q;
	logic                      nack_q;
	logic                      sda_oe_q;
	logic                      sda_o_q;

	// Register state
	logic [7:0]  ctrl_q;
	logic [15:0] tim_q;
	logic [7:0]  led_ctrl_q;
	logic [7:0]  led_cur_q;
	logic [15:0] result_q;
	logic        adc_rst_prev_q;
	logic        meas_q;
	logic [23:0] step_cnt_q;
	logic [16:0] left_q;
	logic        gain_q;
	logic        led_on_q;
	logic        led_dc_q;
	logic [6:0]  led_ma_q;

	wire byte_end  = scl_fall & (bit_cnt_q == 4'd7);
	wire ack_end   = scl_fall & (bit_cnt_q == 4'd8);
	wire addr_hit  = shift_q[7:1] == `NSIC_TGT_ADDR;
	wire reg_wr    = byte_end & (state_q == nsic_pkg::DS_WR) & ~ptr_phase_q;
	wire wr_ctrl   = reg_wr & (ptr_q == `NSIC_PTR_CTRL);
	wire wr_tim_hi = reg_wr & (ptr_q == `NSIC_PTR_TIM_HI);
	wire wr_tim_lo = reg_wr & (ptr_q == `NSIC_PTR_TIM_LO);
	wire wr_led    = reg_wr & (ptr_q == `NSIC_PTR_LED_CTRL);
	wire wr_cur    = reg_wr & (ptr_q == `NSIC_PTR_LED_CUR);
	wire rd_load   = ack_end & ((state_q == nsic_pkg::DS_ADDR & rd_dir_q)
			| (state_q == nsic_pkg::DS_RD & ~nack_q));

	// Monitor bit reads one while no measurement is running
	wire [7:0] ctrl_view = {ctrl_q[7:6], ~meas_q, ctrl_q[4:0]};
	wire [7:0] rd_byte =
		(ptr_q == `NSIC_PTR_CTRL)     ? ctrl_view :
		(ptr_q == `NSIC_PTR_TIM_HI)   ? tim_q[15:8] :
		(ptr_q == `NSIC_PTR_TIM_LO)   ? tim_q[7:0] :
		(ptr_q == `NSIC_PTR_RES_HI)   ? result_q[15:8] :
		(ptr_q == `NSIC_PTR_RES_LO)   ? result_q[7:0] :
		(ptr_q == `NSIC_PTR_LED_CTRL) ? led_ctrl_q :
		(ptr_q == `NSIC_PTR_LED_CUR)  ? led_cur_q : 8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q     <= nsic_pkg::DS_IDLE;
			bit_cnt_q   <= 4'h0;
			shift_q     <= 8'h00;
			tx_q        <= 8'h00;
			ptr_q       <= 8'h00;
			ptr_phase_q <= 1'b0;
			rd_dir_q    <= 1'b0;
			nack_q      <= 1'b0;
			sda_oe_q    <= 1'b0;
			sda_o_q     <= 1'b0;
		end else if (bus_start) begin
			state_q   <= nsic_pkg::DS_ADDR;
			// One below zero: the clock fall that closes the start is not a bit
			bit_cnt_q <= 4'hf;
			sda_oe_q  <= 1'b0;
		end else if (bus_stop) begin
			state_q  <= nsic_pkg::DS_IDLE;
			sda_oe_q <= 1'b0;
		end else begin
			if (scl_rise && bit_cnt_q < 4'd8)
				shift_q <= {shift_q[6:0], sda_s_q[1]};
			if (scl_rise && bit_cnt_q == 4'd8)
				nack_q <= sda_s_q[1];
			if (scl_fall && state_q != nsic_pkg::DS_IDLE)
				bit_cnt_q <= (bit_cnt_q == 4'd8) ? 4'h0 : bit_cnt_q + 4'd1;
			// Read byte: first bit goes out on the fall that ends the ack slot
			if (rd_load) begin
				state_q  <= nsic_pkg::DS_RD;
				tx_q     <= rd_byte;
				sda_oe_q <= ~rd_byte[7];
				ptr_q    <= ptr_q + 8'h01;
			end else if (scl_fall) begin
				case (state_q)
					nsic_pkg::DS_ADDR: begin
						if (bit_cnt_q == 4'd7) begin
							if (addr_hit) begin
								sda_oe_q    <= 1'b1;
								rd_dir_q    <= shift_q[0];
								ptr_phase_q <= 1'b1;
							end else begin
								state_q <= nsic_pkg::DS_IDLE;
							end
						end else if (bit_cnt_q == 4'd8) begin
							sda_oe_q <= 1'b0;
							state_q  <= nsic_pkg::DS_WR;
						end
					end
					nsic_pkg::DS_WR: begin
						if (bit_cnt_q == 4'd7) begin
							sda_oe_q <= 1'b1;
							if (ptr_phase_q) begin
								ptr_q       <= shift_q;
								ptr_phase_q <= 1'b0;
							end else begin
								ptr_q <= ptr_q + 8'h01;
							end
						end else if (bit_cnt_q == 4'd8) begin
							sda_oe_q <= 1'b0;
						end
					end
					nsic_pkg::DS_RD: begin
						if (bit_cnt_q < 4'd7) begin
							tx_q     <= {tx_q[6:0], 1'b0};
							sda_oe_q <= ~tx_q[6];
						end else if (bit_cnt_q == 4'd7) begin
							sda_oe_q <= 1'b0;
						end else begin
							// Host refused the byte: leave the bus alone until next start
							state_q <= nsic_pkg::DS_IDLE;
						end
					end
					default: state_q <= nsic_pkg::DS_IDLE;
				endcase
			end
		end
	end

	assign bus.d_sda_oe = sda_oe_q;
	assign bus.d_sda_o  = sda_o_q;

	////////////////////////////////////////////////////////////////////////////////
	// Measurement timer

	wire [1:0] step_code = ctrl_q[`NSIC_CTRL_STEP_HI:`NSIC_CTRL_STEP_LO];
	wire [23:0] step_len =
		(step_code == 2'h0) ? 24'(STEP0_CYC) :
		(step_code == 2'h1) ? 24'(STEP1_CYC) :
		(step_code == 2'h2) ? 24'(STEP2_CYC) : 24'(STEP3_CYC);
	wire manual = ctrl_q[`NSIC_CTRL_MODE];
	wire [16:0] steps_total = manual ? 17'(tim_q * `NSIC_MAN_STEPS)
			: 17'(`NSIC_FIX_STEPS);
	wire meas_halt = ctrl_q[`NSIC_CTRL_ADC_RST] | ctrl_q[`NSIC_CTRL_STBY];
	wire meas_start = adc_rst_prev_q & ~meas_halt;
	wire step_tick = meas_q & (step_cnt_q == step_len - 24'd1);
	wire meas_last = step_tick & (left_q <= 17'd1);
	wire single_done = meas_last & manual & ~meas_halt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meas_q     <= 1'b0;
			step_cnt_q <= 24'h0;
			left_q     <= 17'h0;
			result_q   <= 16'h0000;
		end else begin
			if (meas_halt) begin
				meas_q <= 1'b0;
			end else if (meas_start) begin
				meas_q     <= 1'b1;
				step_cnt_q <= 24'h0;
				left_q     <= steps_total;
			end else if (meas_q) begin
				step_cnt_q <= step_tick ? 24'h0 : step_cnt_q + 24'd1;
				if (step_tick)
					left_q <= left_q - 17'd1;
				if (meas_last) begin
					result_q <= sample_data;
					if (manual)
						meas_q <= 1'b0;
					else
						left_q <= steps_total;
				end
			end
			// Register-reset bit keeps the result cleared
			if (ctrl_q[`NSIC_CTRL_REG_RST])
				result_q <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register writes

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q         <= `NSIC_CTRL_INIT;
			tim_q          <= `NSIC_TIM_INIT;
			led_ctrl_q     <= `NSIC_LED_CTRL_INIT;
			led_cur_q      <= `NSIC_LED_CUR_INIT;
			adc_rst_prev_q <= 1'b1;
		end else begin
			adc_rst_prev_q <= ctrl_q[`NSIC_CTRL_ADC_RST];
			if (wr_ctrl)
				ctrl_q <= shift_q;
			// Own standby set beats a simultaneous host write
			if (single_done)
				ctrl_q[`NSIC_CTRL_STBY] <= 1'b1;
			if (wr_tim_hi)
				tim_q[15:8] <= shift_q;
			if (wr_tim_lo)
				tim_q[7:0] <= shift_q;
			if (wr_led)
				led_ctrl_q <= shift_q;
			if (wr_cur)
				led_cur_q <= shift_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// LED driver and user outputs

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_on_q <= 1'b0;
			led_dc_q <= 1'b0;
			led_ma_q <= 7'h00;
			gain_q   <= 1'b0;
		end else begin
			// Re-asserting reset alone does not stop a running driver
			if (led_ctrl_q[`NSIC_LED_STBY])
				led_on_q <= 1'b0;
			else if (!led_ctrl_q[`NSIC_LED_RST])
				led_on_q <= 1'b1;
			led_dc_q <= led_ctrl_q[`NSIC_LED_DC];
			led_ma_q <= led_on_q ? {led_cur_q[7:4], 3'h0} : 7'h00;
			gain_q   <= ctrl_q[`NSIC_CTRL_GAIN];
		end
	end

	assign integrating = meas_q;
	assign gain_low    = gain_q;
	assign led_drive   = led_on_q;
	assign led_dc_mode = led_dc_q;
	assign led_ma      = led_ma_q;

endmodule

// file: hw/nsic_host.sv
// Host end: APB-programmed I2C controller that issues sensor register writes and reads
`timescale 1ns/1ps
`include "nsic_params.svh"

module nsic_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	nsic_if.host             bus
);

	////////////////////////////////////////////////////////////////////////////////
	// APB slave

	nsic_pkg::nsic_host_state_e state_q;
	logic [1:0]  cnt_q;
	logic        rd_q;
	logic [7:0]  ptr_q;
	logic [23:0] wdata_q;
	logic        nack_q;
	logic [15:0] rdata_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	wire busy      = state_q == nsic_pkg::HS_RUN;
	wire setup     = psel & ~penable;
	wire acc_wr    = psel & penable & pready_q & pwrite & ~busy;
	wire hit_cmd   = paddr == `NSIC_APB_CMD;
	wire hit_ptr   = paddr == `NSIC_APB_PTR;
	wire hit_wdata = paddr == `NSIC_APB_WDATA;
	wire hit_stat  = paddr == `NSIC_APB_STATUS;
	wire hit_rdata = paddr == `NSIC_APB_RDATA;
	wire mapped    = hit_cmd | hit_ptr | hit_wdata | hit_stat | hit_rdata;
	wire go        = acc_wr & hit_cmd & pwdata[8];
	wire [31:0] rd_mux =
		hit_cmd   ? {27'h0, rd_q, 2'h0, cnt_q} :
		hit_ptr   ? {24'h0, ptr_q} :
		hit_wdata ? {8'h0, wdata_q} :
		hit_stat  ? {30'h0, nack_q, busy} :
		hit_rdata ? {16'h0, rdata_q} : 32'h0;

	// Zero-wait slave: answer is ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
			cnt_q     <= 2'h0;
			rd_q      <= 1'b0;
			ptr_q     <= 8'h00;
			wdata_q   <= 24'h0;
		end else begin
			pready_q <= setup;
			if (setup) begin
				prdata_q  <= rd_mux;
				pslverr_q <= ~mapped;
			end
			if (acc_wr && hit_cmd) begin
				cnt_q <= pwdata[1:0];
				rd_q  <= pwdata[4];
			end
			if (acc_wr && hit_ptr)
				ptr_q <= pwdata[7:0];
			if (acc_wr && hit_wdata)
				wdata_q <= pwdata[23:0];
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	////////////////////////////////////////////////////////////////////////////////
	// Transfer sequencer

	logic [1:0]  sda_s_q;
	logic [4:0]  qdiv_q;
	logic [2:0]  idx_q;
	logic [1:0]  ph_q;
	logic [3:0]  bit_q;
	logic [7:0]  rx_q;
	logic        scl_oe_q;
	logic        sda_oe_q;
	nsic_pkg::nsic_item_e it_kind;
	logic [7:0]  it_byte;

	wire       qtick    = qdiv_q == 5'(`NSIC_QTR_CYC - 1);
	wire [2:0] stop_idx = rd_q ? 3'd7 : 3'(3'd3 + {1'b0, cnt_q});
	wire       sda_in   = sda_s_q[1];
	wire       tx_bit   = it_byte[3'(4'd7 - bit_q)];

	// Write: S, addr+W, pointer, data bytes, P. Read: S, addr+W, pointer, Sr, addr+R, 2 bytes, P
	always_comb begin
		it_kind = nsic_pkg::IT_STOP;
		it_byte = 8'h00;
		if (idx_q == 3'd0 || (rd_q && idx_q == 3'd3)) begin
			it_kind = nsic_pkg::IT_START;
		end else if (idx_q == 3'd1) begin
			it_kind = nsic_pkg::IT_TX;
			it_byte = {`NSIC_TGT_ADDR, 1'b0};
		end else if (idx_q == 3'd2) begin
			it_kind = nsic_pkg::IT_TX;
			it_byte = ptr_q;
		end else if (rd_q) begin
			if (idx_q == 3'd4) begin
				it_kind = nsic_pkg::IT_TX;
				it_byte = {`NSIC_TGT_ADDR, 1'b1};
			end else if (idx_q == 3'd5) begin
				it_kind = nsic_pkg::IT_RXA;
			end else if (idx_q == 3'd6) begin
				it_kind = nsic_pkg::IT_RXN;
			end
		end else if (idx_q < stop_idx) begin
			it_kind = nsic_pkg::IT_TX;
			it_byte = (idx_q == 3'd3) ? wdata_q[7:0] :
				(idx_q == 3'd4) ? wdata_q[15:8] : wdata_q[23:16];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_s_q  <= 2'h3;
			state_q  <= nsic_pkg::HS_IDLE;
			qdiv_q   <= 5'h0;
			idx_q    <= 3'h0;
			ph_q     <= 2'h0;
			bit_q    <= 4'h0;
			rx_q     <= 8'h00;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			nack_q   <= 1'b0;
			rdata_q  <= 16'h0000;
		end else begin
			sda_s_q <= {sda_s_q[0], bus.sda};
			qdiv_q  <= (qtick || go) ? 5'h0 : qdiv_q + 5'd1;
			if (go) begin
				state_q <= nsic_pkg::HS_RUN;
				idx_q   <= 3'h0;
				ph_q    <= 2'h0;
				bit_q   <= 4'h0;
				nack_q  <= 1'b0;
			end else if (busy && qtick) begin
				ph_q <= ph_q + 2'd1;
				case (it_kind)
					nsic_pkg::IT_START: begin
						if (ph_q == 2'd0)
							sda_oe_q <= 1'b0;
						else if (ph_q == 2'd1)
							scl_oe_q <= 1'b0;
						else if (ph_q == 2'd2)
							sda_oe_q <= 1'b1;
						else begin
							scl_oe_q <= 1'b1;
							idx_q    <= idx_q + 3'd1;
						end
					end
					nsic_pkg::IT_STOP: begin
						if (ph_q == 2'd0)
							sda_oe_q <= 1'b1;
						else if (ph_q == 2'd1)
							scl_oe_q <= 1'b0;
						else if (ph_q == 2'd2)
							sda_oe_q <= 1'b0;
						else
							state_q <= nsic_pkg::HS_IDLE;
					end
					default: begin
						if (ph_q == 2'd0) begin
							if (bit_q < 4'd8)
								sda_oe_q <= (it_kind == nsic_pkg::IT_TX) & ~tx_bit;
							else
								sda_oe_q <= it_kind == nsic_pkg::IT_RXA;
						end else if (ph_q == 2'd1) begin
							scl_oe_q <= 1'b0;
						end else if (ph_q == 2'd2) begin
							if (bit_q < 4'd8)
								rx_q <= {rx_q[6:0], sda_in};
							else if (it_kind == nsic_pkg::IT_TX && sda_in)
								nack_q <= 1'b1;
						end else begin
							scl_oe_q <= 1'b1;
							bit_q    <= (bit_q == 4'd8) ? 4'h0 : bit_q + 4'd1;
							if (bit_q == 4'd8) begin
								// A refused byte ends the transfer with a stop
								idx_q <= nack_q ? stop_idx : idx_q + 3'd1;
								if (it_kind == nsic_pkg::IT_RXA)
									rdata_q[15:8] <= rx_q;
								if (it_kind == nsic_pkg::IT_RXN)
									rdata_q[7:0] <= rx_q;
							end
						end
					end
				endcase
			end
		end
	end

	assign bus.h_scl_oe = scl_oe_q;
	assign bus.h_sda_oe = sda_oe_q;
	assign bus.h_scl_o  = 1'b0;
	assign bus.h_sda_o  = 1'b0;

endmodule

// file: testbench/nsic_assertions.sv
// Protocol checks on the serial bus between the host controller and the sensor
`timescale 1ns/1ps

module nsic_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic h_sda_oe,
	input wire logic d_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic       scl_q;
	logic       sda_q;
	logic [3:0] bit_q;
	logic       first_q;
	logic       rd_q;
	logic       rb_q;
	logic       nak_q;
	logic [7:0] sh_q;
	wire        rise = scl && !scl_q;
	wire        strt = scl && scl_q && sda_q && !sda;
	wire        stop = scl && scl_q && !sda_q && sda;
	wire        ackb = rise && bit_q == 4'h8;
	wire        rdat = !first_q && rd_q;

	////////////////////////////////////////////////////////////////////////////////
	// Byte framing seen on the wire; a start restarts the count mid-byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
			bit_q   <= 4'h0;
			first_q <= 1'b1;
			rd_q    <= 1'b0;
			rb_q    <= 1'b0;
			nak_q   <= 1'b0;
			sh_q    <= 8'h00;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (strt) begin
				bit_q   <= 4'h0;
				first_q <= 1'b1;
				rb_q    <= 1'b0;
				nak_q   <= 1'b0;
			end else if (rise) begin
				bit_q <= ackb ? 4'h0 : bit_q + 4'h1;
				sh_q  <= ackb ? sh_q : {sh_q[6:0], sda};
				if (ackb)
					first_q <= 1'b0;
				if (ackb && rdat)
					rb_q <= 1'b1;
				// After a refused read byte only the host's stop follows
				if (ackb && rdat && sda)
					nak_q <= 1'b1;
				if (first_q && bit_q == 4'h7)
					rd_q <= sda;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	strt_free_a: assert property (strt |-> !d_sda_oe)
		else $error("device holds data line at start");
	stop_free_a: assert property (stop |-> !d_sda_oe)
		else $error("device holds data line at stop");
	dev_edge_a: assert property ($changed(d_sda_oe) |-> !scl)
		else $error("device changed data line while clock high");
	addr_ack_a: assert property (ackb && first_q && sh_q[7:1] == 7'h2a |-> d_sda_oe && !sda)
		else $error("own address not acknowledged");
	wr_ack_a: assert property (ackb && !first_q && !rd_q |-> d_sda_oe && !h_sda_oe)
		else $error("written byte not acknowledged");
	host_bits_a: assert property (rise && bit_q < 4'h8 && !rdat |-> !d_sda_oe)
		else $error("device drove a host bit");
	rd_bits_a: assert property (rise && bit_q < 4'h8 && rdat && !nak_q |-> !h_sda_oe)
		else $error("host drove a read data bit");
	rd_ack_a: assert property (ackb && rdat |-> !d_sda_oe && sda == rb_q)
		else $error("read byte ack pattern wrong");
endmodule

// file: testbench/test_nir_sensor_i2c_control.sv
// Testbench joining host controller and sensor over the serial bus
`timescale 1ns/1ps
`include "nsic_params.svh"

module test_nir_sensor_i2c_control;
	localparam int STEP1 = 8;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] sample_data;
	logic        integrating;
	logic        gain_low;
	logic        led_drive;
	logic        led_dc_mode;
	logic [6:0]  led_ma;
	logic [31:0] q;
	logic        e;
	int          num_errors;
	int          checks_done;
	int          hi_cnt = 0;

	nsic_if nsic_if_inst ();
	nsic_host nsic_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus(nsic_if_inst));
	nsic_device #(.STEP0_CYC(4), .STEP1_CYC(STEP1), .STEP2_CYC(12), .STEP3_CYC(16))
		nsic_device_inst (.pclk(pclk), .presetn(presetn), .bus(nsic_if_inst),
		.sample_data(sample_data), .integrating(integrating), .gain_low(gain_low),
		.led_drive(led_drive), .led_dc_mode(led_dc_mode), .led_ma(led_ma));
	nsic_assertions nsic_assertions_inst (.pclk(pclk), .presetn(presetn),
		.h_sda_oe(nsic_if_inst.h_sda_oe), .d_sda_oe(nsic_if_inst.d_sda_oe),
		.scl(nsic_if_inst.scl), .sda(nsic_if_inst.sda));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		if (num_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Ready and read data are taken at the same rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			num_errors++;
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic i2c(input logic [7:0] ptr, input logic [31:0] cmd, input logic [23:0] wd);
		int n;
		apb(1'b1, `NSIC_APB_PTR, {24'h000000, ptr});
		apb(1'b1, `NSIC_APB_WDATA, {8'h00, wd});
		apb(1'b1, `NSIC_APB_CMD, cmd);
		n = 0;
		do begin
			apb(1'b0, `NSIC_APB_STATUS, 32'h00000000);
			n++;
		end while (q[0] !== 1'b0 && n < 3000);
		chk(q[1:0], 2'h0);
	endtask

	task automatic wr1(input logic [7:0] ptr, input logic [7:0] v);
		i2c(ptr, 32'h00000101, {16'h0000, v});
	endtask

	task automatic rd(input logic [7:0] ptr);
		i2c(ptr, 32'h00000110, 24'h000000);
		apb(1'b0, `NSIC_APB_RDATA, 32'h00000000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic reset_chk();
		chk({integrating, led_drive, led_ma}, 32'h0);
		apb(1'b0, 8'h14, 32'h00000000);
		chk(q, 32'h00000000);
		chk({31'h0, e}, 32'h00000001);
		rd(8'h00);
		chk(q[15:0], 16'hf400);
	endtask

	task automatic fixed_chk();
		sample_data <= 16'h1234;
		wr1(8'h00, 8'h81);
		chk(integrating, 1'b0);
		wr1(8'h00, 8'h01);
		chk(integrating, 1'b1);
		sample_data <= 16'hbeef;
		repeat (5 * 2 * STEP1) @(posedge pclk);
		rd(8'h03);
		chk(q[15:0], 16'hbeef);
		chk(integrating, 1'b1);
		wr1(8'h00, 8'h81);
		chk(integrating, 1'b0);
	endtask

	task automatic manual_chk();
		int n;
		int h0;
		sample_data <= 16'h5a5a;
		i2c(8'h00, 32'h00000103, 24'h65018d);
		chk({gain_low, integrating}, 2'h2);
		h0 = hi_cnt;
		wr1(8'h00, 8'h0d);
		for (n = 0; n < 8000 && integrating === 1'b1; n++) begin
			@(posedge pclk);
		end
		chk(hi_cnt - h0, 357 * 2 * STEP1);
		sample_data <= 16'h0000;
		repeat (100) @(posedge pclk);
		chk(integrating, 1'b0);
		rd(8'h03);
		chk(q[15:0], 16'h5a5a);
		rd(8'h00);
		chk(q[15:0], 16'h6d01);
	endtask

	task automatic led_chk();
		logic [7:0] cur [4];
		logic [6:0] ma [4];
		cur = '{8'h80, 8'h40, 8'h3f, 8'hf0};
		ma = '{7'd64, 7'd32, 7'd24, 7'd120};
		i2c(8'h0e, 32'h00000102, 24'h0060a0);
		chk({led_drive, led_dc_mode}, 2'h1);
		wr1(8'h0e, 8'h20);
		chk({led_drive, led_ma}, {1'b1, 7'd48});
		wr1(8'h0e, 8'ha0);
		chk(led_drive, 1'b1);
		for (int i = 0; i < 4; i++) begin
			wr1(8'h0f, cur[i]);
			chk(led_ma, ma[i]);
		end
		wr1(8'h0e, 8'hc0);
		chk({led_drive, led_ma}, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge pclk)
		if (integrating === 1'b1)
			hi_cnt <= hi_cnt + 1;

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// Whole run is near 45k cycles, so this only fires on a hang
	initial begin
		repeat (80000) @(posedge pclk);
		num_errors++;
		end_sim();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		sample_data = 16'h0000;
		num_errors = 0;
		checks_done = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		reset_chk();
		fixed_chk();
		manual_chk();
		led_chk();
		end_sim();
	end
endmodule
